// ===== src/dcc_pkg.sv
package dcc_pkg;
  // ==========================================================
  // Register map, byte addresses on the Avalon slave
  localparam logic [4:0] DCC_OFS_CTRL   = 5'h00;
  localparam logic [4:0] DCC_OFS_FLAGS  = 5'h04;
  localparam logic [4:0] DCC_OFS_ENABLE = 5'h08;
  localparam logic [4:0] DCC_OFS_PRIO   = 5'h0c;
  localparam logic [4:0] DCC_OFS_CORE   = 5'h10;
  localparam logic [4:0] DCC_OFS_PCFG   = 5'h14;
  localparam logic [4:0] DCC_OFS_DIR    = 5'h18;
  localparam logic [4:0] DCC_OFS_PORT   = 5'h1c;

  // ==========================================================
  // Field positions
  localparam int DCC_BIT_OUT2    = 7;
  localparam int DCC_BIT_OUT1    = 6;
  localparam int DCC_BIT_INV2    = 5;
  localparam int DCC_BIT_INV1    = 4;
  localparam int DCC_BIT_SWITCH  = 3;
  localparam int DCC_BIT_CHANGE  = 6;
  localparam int DCC_BIT_GLOBAL  = 7;
  localparam int DCC_BIT_PERIPH  = 6;
  localparam int DCC_PIN_OUT1    = 4;
  localparam int DCC_PIN_OUT2    = 5;

  // ==========================================================
  // Reset values
  localparam logic [5:0] DCC_RST_CTRL = 6'h07;
  localparam logic [3:0] DCC_RST_PCFG = 4'h0;
  localparam logic [5:0] DCC_RST_DIR  = 6'h3f;

  // ==========================================================
  // Comparator modes
  typedef enum logic [2:0] {
    DCC_M_RESET   = 3'h0,
    DCC_M_ONE_IND = 3'h1,
    DCC_M_TWO_IND = 3'h2,
    DCC_M_COM_OUT = 3'h3,
    DCC_M_COM_REF = 3'h4,
    DCC_M_ONE_OUT = 3'h5,
    DCC_M_FOUR_MX = 3'h6,
    DCC_M_OFF     = 3'h7
  } dcc_mode_e;

  // Power of each comparator per mode, {cmp2, cmp1}
  function automatic logic [1:0] dcc_power(input dcc_mode_e m);
    unique case (m)
      DCC_M_RESET, DCC_M_OFF:     dcc_power = 2'h0;
      DCC_M_ONE_IND, DCC_M_ONE_OUT: dcc_power = 2'h1;
      default:                    dcc_power = 2'h3;
    endcase
  endfunction

  // Modes whose outputs are muxed onto the port pins
  function automatic logic dcc_pin_route(input dcc_mode_e m);
    dcc_pin_route = (m == DCC_M_COM_OUT) || (m == DCC_M_ONE_OUT);
  endfunction
endpackage

// ===== src/dcc_top.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Eight modes chosen by a 3-bit field in the control register.
// - Raw result high when plus input exceeds minus input, else low.
// - Internal reference usable only in mode 110, on both plus inputs.
// - Both outputs read back in control bits 7:6; writes ignored.
// - Pin-routing modes drive pins straight from comparators, unsynchronized; two in mode 011, only the first in mode 101.
// - Port direction bits still gate whether those pins drive.
// - Per-comparator invert bit complements reported and pin output.
// - Flag sets whenever either comparator output changes.
// - Software write of zero clears flag; write of one sets it.
// - Request only when flag and all three enables set; flag sets anyway.
// - Change coinciding with a control access may not set the flag.
// - Mismatch keeps setting flag until a control access ends it.
// - Comparators run in sleep; enabled change interrupt wakes device.
// - Waking from sleep leaves the control register unchanged.
// - Reset returns control register with mode 111, both off.
// - Input pins analog after reset, then follow low port-config bits.
// - Port read returns zero for every analog-configured pin.
// - In mode 110 the switch bit picks which input pin pair is used.
// - Invert 2 at bit 5, invert 1 at bit 4; outputs reset 0, mode 111.
module dcc_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cmp1Raw,
  input  wire logic        cmp2Raw,
  input  wire logic [5:0]  portPinsIn,
  input  wire logic        sleepMode,
  output logic             cmp1PowerOn,
  output logic             cmp2PowerOn,
  output logic             useIntRef,
  output logic             inputSwitch,
  output logic             cmp1PinOut,
  output logic             cmp1PinOe,
  output logic             cmp2PinOut,
  output logic             cmp2PinOe,
  output logic             irqRequest,
  output logic             irqHighPrio,
  output logic             wakeRequest
);
  import dcc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    dcc_mode_e   mode;
    logic        sw;
    logic [1:0]  inv;
    logic [1:0]  outs;
    logic [1:0]  latched;
    logic        flag;
    logic        enable;
    logic        prio;
    logic        global_irq_enable;
    logic        peripheral_irq_enable;
    logic [3:0]  pcfg;
    logic [5:0]  dir;
    logic        waitReq;
    logic [31:0] rdata;
    logic [3:0]  ana;
    logic        irq;
    logic        wake;
    logic [1:0]  pwr;
    logic        refSel;
    logic        swOut;
    logic [1:0]  pinOe;
  } dcc_state_s;

  dcc_state_s st_r;
  dcc_state_s st_nxt;
  logic [1:0] rawOut;
  logic [1:0] power;
  logic       route;
  logic       done;
  logic       ctrlHit;
  logic       mismatch;

  // ==========================================================
  // Live result path
  // raw polarity: the analog core drives 1 for plus above minus
  // invert applied before both readback and pins
  assign power  = dcc_power(st_r.mode);
  assign route  = dcc_pin_route(st_r.mode);
  assign rawOut = {cmp2Raw ^ st_r.inv[1], cmp1Raw ^ st_r.inv[0]} & power;

  // Handshake completes on the edge where waitrequest is seen low
  assign done    = (avs_read || avs_write) && !st_r.waitReq;
  assign ctrlHit = done && (avs_address == DCC_OFS_CTRL);
  // mismatch against the last latched values
  assign mismatch = (st_r.outs != st_r.latched);

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.outs = rawOut;
    // One wait state, then the access completes
    st_nxt.waitReq = !((avs_read || avs_write) && st_r.waitReq);
    // analog mask follows the port configuration bits
    st_nxt.ana = ~st_r.pcfg;

    // Read data is prepared in the wait cycle and held
    if ((avs_read || avs_write) && st_r.waitReq) begin
      st_nxt.rdata = 32'h0;
      unique case (avs_address)
        // status bits come from live outputs
        DCC_OFS_CTRL:   st_nxt.rdata[7:0] = {st_r.outs[1], st_r.outs[0], st_r.inv[1],
                                             st_r.inv[0], st_r.sw, st_r.mode};
        DCC_OFS_FLAGS:  st_nxt.rdata[DCC_BIT_CHANGE] = st_r.flag;
        DCC_OFS_ENABLE: st_nxt.rdata[DCC_BIT_CHANGE] = st_r.enable;
        DCC_OFS_PRIO:   st_nxt.rdata[DCC_BIT_CHANGE] = st_r.prio;
        DCC_OFS_CORE:   st_nxt.rdata[7:6] = {st_r.global_irq_enable, st_r.peripheral_irq_enable};
        DCC_OFS_PCFG:   st_nxt.rdata[3:0] = st_r.pcfg;
        DCC_OFS_DIR:    st_nxt.rdata[5:0] = st_r.dir;
        // analog pins read back as zero
        DCC_OFS_PORT:   st_nxt.rdata[5:0] = portPinsIn & {2'h3, ~st_r.ana};
        default:        st_nxt.rdata = 32'h0;
      endcase
    end

    // Register writes at the completing edge
    if (done && avs_write) begin
      unique case (avs_address)
        // field layout; output bits not writable
        DCC_OFS_CTRL: begin
          st_nxt.inv  = {avs_writedata[DCC_BIT_INV2], avs_writedata[DCC_BIT_INV1]};
          st_nxt.sw   = avs_writedata[DCC_BIT_SWITCH];
          // mode field selects one of eight
          st_nxt.mode = dcc_mode_e'(avs_writedata[2:0]);
        end
        // software write sets or clears the flag
        DCC_OFS_FLAGS:  st_nxt.flag   = avs_writedata[DCC_BIT_CHANGE];
        DCC_OFS_ENABLE: st_nxt.enable = avs_writedata[DCC_BIT_CHANGE];
        DCC_OFS_PRIO:   st_nxt.prio   = avs_writedata[DCC_BIT_CHANGE];
        DCC_OFS_CORE: begin
          st_nxt.global_irq_enable  = avs_writedata[DCC_BIT_GLOBAL];
          st_nxt.peripheral_irq_enable = avs_writedata[DCC_BIT_PERIPH];
        end
        DCC_OFS_PCFG: st_nxt.pcfg = avs_writedata[3:0];
        DCC_OFS_DIR:  st_nxt.dir  = avs_writedata[5:0];
        default:      st_nxt.pcfg = st_r.pcfg;
      endcase
    end

    // latch outputs on any control access
    // a change that landed on the edge before is absorbed into the latch
    if (ctrlHit) begin
      st_nxt.latched = st_r.outs;
    end

    // set wins over a software clear in the same cycle
    // the flag keeps setting while the mismatch persists
    if (mismatch && !ctrlHit) begin
      st_nxt.flag = 1'b1;
    end

    // Decoded outputs come from the next state, so the flops track the
    // register with no extra lag and the ports stay glitch free
    st_nxt.pwr      = dcc_power(st_nxt.mode);
    st_nxt.refSel   = (st_nxt.mode == DCC_M_FOUR_MX);
    st_nxt.swOut    = st_nxt.refSel && st_nxt.sw;
    st_nxt.pinOe[0] = dcc_pin_route(st_nxt.mode) && !st_nxt.dir[DCC_PIN_OUT1];
    st_nxt.pinOe[1] = dcc_pin_route(st_nxt.mode) && !st_nxt.dir[DCC_PIN_OUT2]
                      && st_nxt.pwr[1];

    // request needs all enables; flag is set regardless
    st_nxt.irq  = st_nxt.flag && st_nxt.enable && st_nxt.peripheral_irq_enable && st_nxt.global_irq_enable;
    // wake only needs the local enable; logic runs during sleep
    st_nxt.wake = st_nxt.flag && st_nxt.enable && sleepMode;
  end

  // ==========================================================
  // State register
  // reset value; sleep never touches the control fields
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r         <= '0;
      st_r.mode    <= dcc_mode_e'(DCC_RST_CTRL[2:0]);
      st_r.sw      <= DCC_RST_CTRL[3];
      st_r.inv     <= DCC_RST_CTRL[5:4];
      st_r.pcfg    <= DCC_RST_PCFG;
      st_r.dir     <= DCC_RST_DIR;
      st_r.ana     <= 4'hf;
      st_r.waitReq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata    = st_r.rdata;
  assign avs_waitrequest = st_r.waitReq;
  assign cmp1PowerOn     = st_r.pwr[0];
  assign cmp2PowerOn     = st_r.pwr[1];
  // reference only in the four-input mode
  assign useIntRef       = st_r.refSel;
  // switch meaningful only in mode 110
  assign inputSwitch     = st_r.swOut;
  assign irqRequest      = st_r.irq;
  assign irqHighPrio     = st_r.prio;
  assign wakeRequest     = st_r.wake;

  // pins are the unsynchronized comparator result, not a flop
  assign cmp1PinOut = rawOut[0];
  assign cmp2PinOut = rawOut[1];
  // a direction bit of 0 means drive
  assign cmp1PinOe  = st_r.pinOe[0];
  assign cmp2PinOe  = st_r.pinOe[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // All checks run on the one clock and are off while reset is held.
  // The raw comparator inputs are free inputs here, so the checks only
  // relate them to what the block reports; analog accuracy lives elsewhere.
  // A mode change may glitch the outputs; the checks accept that glitch
  // as a real change, which is why software masks the interrupt then.

  mode_reset_a: assert property ($fell(rst) |-> st_r.mode == DCC_M_OFF && st_r.outs == 2'h0)
    else $error("mode not off after reset");

  invert_path_a: assert property (##1 st_r.outs[0] == $past((cmp1Raw ^ st_r.inv[0]) & power[0]))
    else $error("reported output lost inversion");

  flag_set_a: assert property (mismatch && !ctrlHit |=> st_r.flag)
    else $error("change did not set flag");

  irq_gate_a: assert property (irqRequest |-> st_r.flag && st_r.enable && st_r.global_irq_enable && st_r.peripheral_irq_enable)
    else $error("request without all enables");

  irq_set_a: assert property (st_r.flag && st_r.enable && st_r.peripheral_irq_enable && st_r.global_irq_enable && !done
                              |=> irqRequest)
    else $error("request missing with all enables set");

  irq_off_a: assert property (!st_r.global_irq_enable && !done |=> !irqRequest)
    else $error("request while global enable clear");

  latch_access_a: assert property (ctrlHit |=> st_r.latched == $past(st_r.outs))
    else $error("outputs not latched on access");

  latch_hold_a: assert property (!ctrlHit |=> $stable(st_r.latched))
    else $error("latch moved without control access");

  ref_mode_a: assert property (useIntRef |-> st_r.mode == DCC_M_FOUR_MX && power == 2'h3)
    else $error("reference outside mode 110");

  switch_mode_a: assert property (inputSwitch |-> st_r.mode == DCC_M_FOUR_MX && st_r.sw)
    else $error("input switch outside mode 110");

  power_off_a: assert property (st_r.mode == DCC_M_OFF |-> !cmp1PowerOn && !cmp2PowerOn)
    else $error("comparator powered in off mode");

  ctrl_mode_a: assert property (ctrlHit && avs_write
                                |=> st_r.mode == $past(avs_writedata[2:0]))
    else $error("mode field not written");

  invert_write_a: assert property (ctrlHit && avs_write |=> st_r.inv ==
                                   {$past(avs_writedata[DCC_BIT_INV2]),
                                    $past(avs_writedata[DCC_BIT_INV1])})
    else $error("invert bits misplaced");

  pin_oe_a: assert property (cmp1PinOe |-> route && !st_r.dir[DCC_PIN_OUT1])
    else $error("pin drives against direction");

  pin2_oe_a: assert property (cmp2PinOe |-> route && !st_r.dir[DCC_PIN_OUT2] && power[1])
    else $error("second pin drives against direction");

  pin_off_a: assert property (!route |-> !cmp1PinOe && !cmp2PinOe)
    else $error("pin driven outside routing mode");

  pin_value_a: assert property (power[0] |-> cmp1PinOut == (st_r.inv[0] ? !cmp1Raw : cmp1Raw))
    else $error("pin not the live comparator result");

  analog_zero_a: assert property (done && avs_read && avs_address == DCC_OFS_PORT
                                  && st_r.ana[0] |-> avs_readdata[0] == 1'b0)
    else $error("analog pin read nonzero");

  analog_mask_a: assert property (##1 st_r.ana == ~$past(st_r.pcfg))
    else $error("analog mask not following config");

  flag_clear_a: assert property (done && avs_write && avs_address == DCC_OFS_FLAGS
                                 && !avs_writedata[DCC_BIT_CHANGE] && !mismatch
                                 |=> !st_r.flag)
    else $error("flag not cleared by write");

  flag_soft_a: assert property (done && avs_write && avs_address == DCC_OFS_FLAGS
                                && avs_writedata[DCC_BIT_CHANGE] |=> st_r.flag)
    else $error("flag not set by software write");

  flag_keep_a: assert property (st_r.flag && !(done && avs_write) |=> st_r.flag)
    else $error("flag dropped without a write");

  status_ro_a: assert property (ctrlHit && avs_write |=> st_r.outs == $past(rawOut))
    else $error("status bits took write data");

  wake_sleep_a: assert property (wakeRequest |-> $past(sleepMode))
    else $error("wake request while awake");

  sleep_hold_a: assert property (sleepMode && !done |=> $stable(st_r.mode))
    else $error("control register moved in sleep");

  // One wait state per access
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");

  flag_irq_c: cover property (mismatch ##1 st_r.flag ##[1:20] irqRequest);
  wake_c:     cover property (sleepMode && wakeRequest);
  pin_c:      cover property (cmp1PinOe && cmp2PinOe);
  switch_c:   cover property (inputSwitch && useIntRef);
  soft_c:     cover property (done && avs_write && avs_address == DCC_OFS_FLAGS);
endmodule

// ===== tb/dcc_analog_model.sv
`timescale 1ns/1ps
// ==========================================================
// Analog side: pin voltages in millivolts and the internal reference
module dcc_analog_model (
  input  wire logic sys_clk,
  input  int        vin1Plus,
  input  int        vin1Minus,
  input  int        vin2Plus,
  input  int        vin2Minus,
  input  int        intRef,
  input  wire logic useIntRef,
  output logic      cmp1Raw,
  output logic      cmp2Raw
);
  // high when plus above minus
  // Registered so the raw result is synchronous, as the design expects
  always_ff @(posedge sys_clk) begin
    cmp1Raw <= (useIntRef ? intRef : vin1Plus) > vin1Minus;
    cmp2Raw <= (useIntRef ? intRef : vin2Plus) > vin2Minus;
  end
endmodule

// ===== tb/dcc_top_bench.sv
`timescale 1ns/1ps
module dcc_top_bench;
  import dcc_pkg::*;
  // ==========================================================
  // Stimulus and wiring
  logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, sleepMode = 0;
  logic [4:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [5:0]  portPinsIn = 0;
  logic        avs_waitrequest, cmp1Raw, cmp2Raw, p1On, p2On, useIntRef, inputSwitch;
  logic        pin1, oe1, pin2, oe2, irqRequest, irqHighPrio, wakeRequest;
  int          fail_count = 0, total_checks = 0;
  int          v1p = 600, v1m = 500, v2p = 400, v2m = 500;
  dcc_top u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp1Raw(cmp1Raw),
    .cmp2Raw(cmp2Raw), .portPinsIn(portPinsIn), .sleepMode(sleepMode), .cmp1PowerOn(p1On),
    .cmp2PowerOn(p2On), .useIntRef(useIntRef), .inputSwitch(inputSwitch), .cmp1PinOut(pin1),
    .cmp1PinOe(oe1), .cmp2PinOut(pin2), .cmp2PinOe(oe2), .irqRequest(irqRequest),
    .irqHighPrio(irqHighPrio), .wakeRequest(wakeRequest));
  dcc_analog_model u_model (.sys_clk(sys_clk), .vin1Plus(v1p), .vin1Minus(v1m),
    .vin2Plus(v2p), .vin2Minus(v2m), .intRef(450), .useIntRef(useIntRef),
    .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw));
  always #5 sys_clk = ~sys_clk;
  // ==========================================================
  // Tasks; waitrequest is sampled at the edge before the design updates it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog, far beyond the couple of hundred cycles the tests need
  initial begin
    cyc(20000);
    fail_count++;
    final_report();
  end
  // ==========================================================
  // Test sequence
  initial begin
    cyc(20);
    rst <= 1'b0;
    portPinsIn <= 6'h3f;
    cyc(1);
    rd("ctrl reset", DCC_OFS_CTRL, 32'h07);
    rd("dir reset", DCC_OFS_DIR, 32'h3f);
    rd("port analog", DCC_OFS_PORT, 32'h30);
    rd("unmapped", 5'h02, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(DCC_OFS_CTRL, m);
      xfer(1'b0, DCC_OFS_CTRL, 32'h0);
      chk("mode", m, q & 32'h3f);
      chk("power", (m == 0 || m == 7) ? 0 : (m == 1 || m == 5) ? 1 : 3, {p2On, p1On});
      chk("intref", m == 6, useIntRef);
    end
    wr(DCC_OFS_CTRL, 32'h0e);
    cyc(2);
    chk("switch", 1, inputSwitch);
    $display("test modes done");
    wr(DCC_OFS_CTRL, 32'hc2);
    cyc(3);
    rd("out bits", DCC_OFS_CTRL, 32'h42);
    wr(DCC_OFS_CTRL, 32'h32);
    cyc(3);
    rd("inverted", DCC_OFS_CTRL, 32'hb2);
    wr(DCC_OFS_CTRL, 32'h02);
    cyc(3);
    rd("latch", DCC_OFS_CTRL, 32'h42);
    wr(DCC_OFS_FLAGS, 32'h0);
    rd("flag clear", DCC_OFS_FLAGS, 32'h0);
    v2p <= 700;
    cyc(5);
    rd("flag change", DCC_OFS_FLAGS, 32'h40);
    wr(DCC_OFS_FLAGS, 32'h0);
    rd("mismatch", DCC_OFS_FLAGS, 32'h40);
    rd("ctrl end", DCC_OFS_CTRL, 32'hc2);
    wr(DCC_OFS_FLAGS, 32'h0);
    rd("flag ended", DCC_OFS_FLAGS, 32'h0);
    wr(DCC_OFS_FLAGS, 32'h40);
    rd("flag soft", DCC_OFS_FLAGS, 32'h40);
    $display("test flag done");
    wr(DCC_OFS_ENABLE, 32'h40);
    wr(DCC_OFS_PRIO, 32'h40);
    wr(DCC_OFS_CORE, 32'hc0);
    cyc(2);
    chk("irq", 1, irqRequest);
    chk("prio", 1, irqHighPrio);
    wr(DCC_OFS_CORE, 32'h80);
    cyc(2);
    chk("irq off", 0, irqRequest);
    rd("flag kept", DCC_OFS_FLAGS, 32'h40);
    sleepMode <= 1'b1;
    cyc(3);
    chk("wake", 1, wakeRequest);
    sleepMode <= 1'b0;
    rd("ctrl sleep", DCC_OFS_CTRL, 32'hc2);
    $display("test irq done");
    wr(DCC_OFS_ENABLE, 32'h0);
    v2p <= 400;
    wr(DCC_OFS_DIR, 32'h0);
    wr(DCC_OFS_CTRL, 32'h03);
    cyc(3);
    chk("pins", 4'b1011, {oe2, pin2, oe1, pin1});
    wr(DCC_OFS_CTRL, 32'h13);
    cyc(3);
    chk("pin inv", 0, pin1);
    wr(DCC_OFS_DIR, 32'h3f);
    cyc(2);
    chk("pin oe", 0, {oe2, oe1});
    wr(DCC_OFS_PCFG, 32'h5);
    rd("port mix", DCC_OFS_PORT, 32'h35);
    $display("test pins done");
    wr(DCC_OFS_CTRL, 32'h07);
    cyc(2);
    chk("off power", 0, {p2On, p1On});
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    rd("ctrl rereset", DCC_OFS_CTRL, 32'h07);
    $display("test reset again done");
    final_report();
  end
endmodule
